// [dmsp_pkg.sv]
// Purpose: shared constants and types for the dual mode serial port
// Assumes: one clock domain, plain register port with 3-bit address
// Notes: register offsets and the reload register address are local choices
package dmsp_pkg;

  // ==========================================================
  // register map
  localparam logic [2:0] ADDR_RX_CTRL = 3'h0;
  localparam logic [2:0] ADDR_TX_CTRL = 3'h1;
  localparam logic [2:0] ADDR_STATUS = 3'h2;
  localparam logic [2:0] ADDR_BUFFER = 3'h3;
  localparam logic [2:0] ADDR_RELOAD = 3'h4;

  // ==========================================================
  // reset values
  localparam logic [7:0] RX_CTRL_RESET = 8'h00;
  localparam logic [7:0] TX_CTRL_RESET = 8'h04;
  localparam logic [5:0] STATUS_RESET = 6'h00;
  localparam logic [7:0] RELOAD_RESET = 8'h00;
  localparam logic [7:0] BUFFER_RESET = 8'h00;

  // ==========================================================
  // status bit positions
  localparam int ST_FRAMING = 0;
  localparam int ST_OVERRUN = 1;
  localparam int ST_PARITY = 2;
  localparam int ST_TX_EMPTY = 3;
  localparam int ST_TX_DONE = 4;
  localparam int ST_RX_DONE = 5;
  localparam int TX_FIXED_BIT = 2;

  // ==========================================================
  // timing counts
  localparam logic [7:0] TIMER_TOP = 8'hFF;
  localparam logic [3:0] OVS_MID = 4'h7;
  localparam logic [3:0] OVS_LAST = 4'hF;
  localparam logic [1:0] SYNC_RISE_PHASE = 2'h1;
  localparam logic [1:0] SYNC_FALL_PHASE = 2'h3;
  localparam logic [3:0] BITS_LONG = 4'h8;
  localparam logic [3:0] BITS_SHORT = 4'h7;

  // ==========================================================
  // control register layouts, msb first
  typedef struct packed {
    logic rx_enable;
    logic rx_done_irq_enable;
    logic rx_parity_polarity;
    logic rx_parity_enable;
    logic rx_slave_select;
    logic baud_clock_select;
    logic rx_length_select;
    logic rx_mode_select;
  } dmsp_rx_ctrl_t;

  typedef struct packed {
    logic tx_done_irq_enable;
    logic tx_empty_irq_enable;
    logic tx_parity_polarity;
    logic tx_parity_enable;
    logic tx_stop_length;
    logic fixed_one;
    logic tx_length_select;
    logic tx_mode_select;
  } dmsp_tx_ctrl_t;

  typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_PARITY, RX_STOP} dmsp_rx_state_t;
  typedef enum logic [2:0] {TX_IDLE, TX_WAIT, TX_DATA, TX_PARITY, TX_STOP} dmsp_tx_state_t;

endpackage : dmsp_pkg

// [dmsp_serial_port.sv]
// Purpose: dual mode (asynchronous / clocked) serial port with register port
// Assumes: 125 MHz clk, timer input clock is clk, pins asynchronous to clk
// Notes: pin enables are active low; irq outputs are one-cycle requests
// Functional notes
// - every reset loads receive control with zero, reception off.
// - bit 0 picks async or sync receive, bit 1 picks 8 or 7 bits.
// - bit 2 picks timer or external baud clock; async shift is 1/16.
// - bit 3 picks master or slave receive, only in sync mode.
// - bits 4 and 5 enable parity and choose polarity, async only.
// - bit 6 gates the receive complete event onto a request.
// - bit 7 enables reception; clear means nothing is received.
// - status resets to zero; bits 6 and 7 read zero, ignore writes.
// - async stop bit sampled low sets framing error.
// - completion with previous byte unread sets overrun error.
// - async parity mismatch sets parity error.
// - error bits change only when a reception completes.
// - tx empty, tx done and rx done events set bits 3, 4, 5.
// - status bits stay set until software writes zero.
// - buffer address writes the tx holder, reads the rx data.
// - buffer write loads tx shifter, raises tx empty, starts sending.
// - reception end copies shifter to buffer, raises rx done, holds it.
// - seven-bit receive puts data in bits 0-6, bit 7 reads one.
// - separate 8-bit shifters, invisible to software.
// - async frame start, data, optional parity, 2 or 1 stops; sync data only.
// - transmit control resets to 04h; bit 2 reads one, ignores writes.
// - baud is clock over (256 - reload), then 16 async or 4 sync.
// - shifter loads one clock after write; start on next shift fall, lsb first.
module dmsp_serial_port
  import dmsp_pkg::*;
(
  input wire logic clk,
  input wire logic resetn,
  input wire logic [2:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr_stb,
  input wire logic rd_stb,
  output logic [7:0] rdata,
  input wire logic rx_data_pin,
  output logic tx_data_pin,
  input wire logic rx_clock_pin_in,
  output logic rx_clock_pin_out,
  output logic rx_clock_pin_oe_n,
  input wire logic tx_clock_pin_in,
  output logic tx_clock_pin_out,
  output logic tx_clock_pin_oe_n,
  output logic rx_done_irq,
  output logic tx_empty_irq,
  output logic tx_done_irq
);

  // ==========================================================
  // helpers
  function automatic logic calc_parity(input logic [7:0] d, input logic len7, input logic odd);
    calc_parity = (^{d[7] & ~len7, d[6:0]}) ^ odd;
  endfunction : calc_parity

  function automatic logic [3:0] frame_bits(input logic len7);
    frame_bits = len7 ? BITS_SHORT : BITS_LONG;
  endfunction : frame_bits

  dmsp_rx_ctrl_t rx_ctrl;
  dmsp_tx_ctrl_t tx_ctrl;
  logic [5:0] status;
  logic [7:0] reload;
  logic [7:0] rx_buf;
  logic [7:0] tx_hold;
  logic hold_full;
  logic rx_unread;
  logic [5:0] set_vec;

  // ==========================================================
  // pin synchronisers, stage one is read only by stage two
  logic [1:0] rxd_s;
  logic [1:0] rxc_s;
  logic [1:0] txc_s;
  logic rxd_d;
  logic rxc_d;
  logic txc_d;
  always_ff @(posedge clk) begin
    if (!resetn) begin
      rxd_s <= 2'h3;
      rxc_s <= 2'h3;
      txc_s <= 2'h3;
      rxd_d <= 1'b1;
      rxc_d <= 1'b1;
      txc_d <= 1'b1;
    end else begin
      rxd_s <= {rxd_s[0], rx_data_pin};
      rxc_s <= {rxc_s[0], rx_clock_pin_in};
      txc_s <= {txc_s[0], tx_clock_pin_in};
      rxd_d <= rxd_s[1];
      rxc_d <= rxc_s[1];
      txc_d <= txc_s[1];
    end
  end
  logic rxd;
  assign rxd = rxd_s[1];

  // ==========================================================
  // register writes
  logic wr_rx;
  logic wr_tx;
  logic wr_st;
  logic wr_buf;
  logic rd_buf;
  assign wr_rx = wr_stb && addr == ADDR_RX_CTRL;
  assign wr_tx = wr_stb && addr == ADDR_TX_CTRL;
  assign wr_st = wr_stb && addr == ADDR_STATUS;
  assign wr_buf = wr_stb && addr == ADDR_BUFFER;
  assign rd_buf = rd_stb && addr == ADDR_BUFFER;

  // control registers; fixed bit kept at one whatever is written
  always_ff @(posedge clk) begin
    if (!resetn) begin
      rx_ctrl <= RX_CTRL_RESET;
      tx_ctrl <= TX_CTRL_RESET;
      reload <= RELOAD_RESET;
    end else begin
      if (wr_rx) rx_ctrl <= wdata;
      if (wr_tx) tx_ctrl <= wdata | (8'h01 << TX_FIXED_BIT);
      if (wr_stb && addr == ADDR_RELOAD) reload <= wdata;
    end
  end

  // sticky status; a hardware set wins over a software clear
  always_ff @(posedge clk) begin
    if (!resetn) begin
      status <= STATUS_RESET;
    end else begin
      status <= (wr_st ? wdata[5:0] : status) | set_vec;
    end
  end

  // read port, data one cycle after the strobe; unmapped reads zero
  always_ff @(posedge clk) begin
    if (!resetn) begin
      rdata <= 8'h00;
    end else if (rd_stb) begin
      unique case (addr)
        ADDR_RX_CTRL: rdata <= rx_ctrl;
        ADDR_TX_CTRL: rdata <= tx_ctrl;
        ADDR_STATUS: rdata <= {2'b00, status};
        ADDR_BUFFER: rdata <= rx_buf;
        ADDR_RELOAD: rdata <= reload;
        default: rdata <= 8'h00;
      endcase
    end else begin
      rdata <= 8'h00;
    end
  end

  // ==========================================================
  // baud generator: reload counter then shared dividers
  logic [7:0] tmr;
  logic tmr_tick;
  logic ext_tick;
  logic baud_tick;
  logic [1:0] phase;
  logic sync_rise;
  logic sync_fall;
  logic [3:0] tx_div;
  logic tx_async_tick;
  assign tmr_tick = tmr == TIMER_TOP;
  assign ext_tick = rxc_s[1] && !rxc_d;
  // external source only exists for the async baud
  assign baud_tick = rx_ctrl.baud_clock_select ? ext_tick : tmr_tick;
  assign sync_rise = tmr_tick && phase == SYNC_RISE_PHASE;
  assign sync_fall = tmr_tick && phase == SYNC_FALL_PHASE;
  assign tx_async_tick = baud_tick && tx_div == OVS_LAST;

  always_ff @(posedge clk) begin
    if (!resetn) begin
      tmr <= RELOAD_RESET;
      phase <= 2'h0;
      tx_div <= 4'h0;
    end else begin
      tmr <= tmr_tick ? reload : tmr + 8'h01;
      if (tmr_tick) phase <= phase + 2'h1;
      if (baud_tick) tx_div <= tx_div + 4'h1;
    end
  end
  logic sclk;
  assign sclk = phase[1];

  // ==========================================================
  // transmitter
  dmsp_tx_state_t tx_state;
  logic [7:0] tx_shift;
  logic [3:0] tx_cnt;
  logic tx_par;
  logic tx_extra_stop;
  logic tx_tick;
  logic tx_load;
  logic tx_end;
  logic tx_sync;
  logic tx_master;
  assign tx_sync = tx_ctrl.tx_mode_select;
  assign tx_master = tx_sync && !tx_ctrl.tx_stop_length;
  // slave shifts on the peer's falling clock edge
  assign tx_tick = !tx_sync ? tx_async_tick :
                   tx_master ? sync_fall : (!txc_s[1] && txc_d);
  assign tx_load = tx_state == TX_IDLE && hold_full;
  assign tx_end = tx_tick && ((tx_state == TX_STOP && !tx_extra_stop) ||
                  (tx_state == TX_DATA && tx_sync &&
                   tx_cnt == frame_bits(tx_ctrl.tx_length_select)));

  // transmit holder; a new write during the load keeps it full
  always_ff @(posedge clk) begin
    if (!resetn) begin
      tx_hold <= BUFFER_RESET;
      hold_full <= 1'b0;
    end else begin
      if (wr_buf) tx_hold <= wdata;
      hold_full <= wr_buf || (hold_full && !tx_load);
    end
  end

  // frame sequencer
  always_ff @(posedge clk) begin
    if (!resetn) begin
      tx_state <= TX_IDLE;
      tx_shift <= 8'h00;
      tx_cnt <= 4'h0;
      tx_par <= 1'b0;
      tx_extra_stop <= 1'b0;
      tx_data_pin <= 1'b1;
    end else begin
      unique case (tx_state)
        TX_IDLE: begin
          if (tx_load) begin
            tx_shift <= tx_hold;
            tx_par <= calc_parity(tx_hold, tx_ctrl.tx_length_select, tx_ctrl.tx_parity_polarity);
            tx_state <= TX_WAIT;
          end
        end
        TX_WAIT: begin
          if (tx_tick) begin
            tx_state <= TX_DATA;
            if (tx_sync) begin
              tx_data_pin <= tx_shift[0];
              tx_shift <= {1'b0, tx_shift[7:1]};
              tx_cnt <= 4'h1;
            end else begin
              tx_data_pin <= 1'b0;
              tx_cnt <= 4'h0;
            end
          end
        end
        TX_DATA: begin
          if (tx_tick) begin
            if (tx_cnt != frame_bits(tx_ctrl.tx_length_select)) begin
              tx_data_pin <= tx_shift[0];
              tx_shift <= {1'b0, tx_shift[7:1]};
              tx_cnt <= tx_cnt + 4'h1;
            end else if (tx_sync) begin
              tx_state <= TX_IDLE;
              tx_data_pin <= 1'b1;
            end else if (tx_ctrl.tx_parity_enable) begin
              tx_data_pin <= tx_par;
              tx_state <= TX_PARITY;
            end else begin
              tx_data_pin <= 1'b1;
              tx_extra_stop <= !tx_ctrl.tx_stop_length;
              tx_state <= TX_STOP;
            end
          end
        end
        TX_PARITY: begin
          if (tx_tick) begin
            tx_data_pin <= 1'b1;
            tx_extra_stop <= !tx_ctrl.tx_stop_length;
            tx_state <= TX_STOP;
          end
        end
        TX_STOP: begin
          if (tx_tick) begin
            if (tx_extra_stop) tx_extra_stop <= 1'b0;
            else tx_state <= TX_IDLE;
          end
        end
      endcase
    end
  end

  // master clock toggles only while a frame is shifting and idles high; the pin is driven whenever in master mode
  logic tx_busy;
  assign tx_busy = tx_state == TX_DATA;
  assign tx_clock_pin_out = sclk || !tx_busy;
  assign tx_clock_pin_oe_n = !tx_master;

  // ==========================================================
  // receiver
  dmsp_rx_state_t rx_state;
  logic [7:0] rx_shift;
  logic [3:0] rx_ovs;
  logic [3:0] rx_cnt;
  logic rx_par_bit;
  logic rx_ferr;
  logic rx_extra_stop;
  logic rx_complete;
  logic rx_sync;
  logic rx_master;
  logic rx_sample;
  logic [7:0] rx_word;
  assign rx_sync = rx_ctrl.rx_mode_select;
  assign rx_master = rx_sync && !rx_ctrl.rx_slave_select;
  assign rx_sample = baud_tick && rx_ovs == OVS_LAST;
  // seven-bit data sits one place high in the shifter
  assign rx_word = rx_ctrl.rx_length_select ? {1'b1, rx_shift[7:1]} : rx_shift;

  logic rx_sync_tick;
  assign rx_sync_tick = rx_master ? sync_rise : (rxc_s[1] && !rxc_d);

  always_ff @(posedge clk) begin
    if (!resetn) begin
      rx_state <= RX_IDLE;
      rx_shift <= 8'h00;
      rx_ovs <= 4'h0;
      rx_cnt <= 4'h0;
      rx_par_bit <= 1'b0;
      rx_ferr <= 1'b0;
      rx_extra_stop <= 1'b0;
      rx_complete <= 1'b0;
    end else begin
      rx_complete <= 1'b0;
      if (baud_tick) rx_ovs <= rx_ovs + 4'h1;
      if (!rx_ctrl.rx_enable) begin
        rx_state <= RX_IDLE;
      end else begin
        unique case (rx_state)
          RX_IDLE: begin
            rx_cnt <= 4'h0;
            rx_ferr <= 1'b0;
            if (rx_sync) begin
              rx_state <= RX_DATA;
            end else if (!rxd && rxd_d) begin
              rx_state <= RX_START;
              rx_ovs <= 4'h0;
            end
          end
          RX_START: begin
            // recheck at the centre so a glitch is not taken as a start
            if (baud_tick && rx_ovs == OVS_MID) begin
              rx_ovs <= 4'h0;
              rx_state <= rxd ? RX_IDLE : RX_DATA;
            end
          end
          RX_DATA: begin
            if (rx_sync ? rx_sync_tick : rx_sample) begin
              rx_shift <= {rxd, rx_shift[7:1]};
              rx_cnt <= rx_cnt + 4'h1;
              if (rx_cnt + 4'h1 == frame_bits(rx_ctrl.rx_length_select)) begin
                if (rx_sync) begin
                  rx_complete <= 1'b1;
                  rx_state <= RX_IDLE;
                end else if (rx_ctrl.rx_parity_enable) begin
                  rx_state <= RX_PARITY;
                end else begin
                  rx_extra_stop <= !tx_ctrl.tx_stop_length;
                  rx_state <= RX_STOP;
                end
              end
            end
          end
          RX_PARITY: begin
            if (rx_sample) begin
              rx_par_bit <= rxd;
              rx_extra_stop <= !tx_ctrl.tx_stop_length;
              rx_state <= RX_STOP;
            end
          end
          RX_STOP: begin
            if (rx_sample) begin
              rx_ferr <= rx_ferr || !rxd;
              if (rx_extra_stop) begin
                rx_extra_stop <= 1'b0;
              end else begin
                rx_complete <= 1'b1;
                rx_state <= RX_IDLE;
              end
            end
          end
          default: rx_state <= RX_IDLE;
        endcase
      end
    end
  end

  // receive buffer and unread tracking; a new byte beats a same-cycle read
  logic rx_perr;
  assign rx_perr = rx_ctrl.rx_parity_enable && !rx_sync &&
                   (rx_par_bit != calc_parity(rx_word, rx_ctrl.rx_length_select,
                                              rx_ctrl.rx_parity_polarity));
  always_ff @(posedge clk) begin
    if (!resetn) begin
      rx_buf <= BUFFER_RESET;
      rx_unread <= 1'b0;
    end else begin
      if (rx_complete) rx_buf <= rx_word;
      rx_unread <= rx_complete || (rx_unread && !rd_buf);
    end
  end

  // status set terms; error bits only on a completion
  always_comb begin
    set_vec = 6'h00;
    set_vec[ST_FRAMING] = rx_complete && !rx_sync && rx_ferr;
    set_vec[ST_OVERRUN] = rx_complete && rx_unread;
    set_vec[ST_PARITY] = rx_complete && rx_perr;
    set_vec[ST_TX_EMPTY] = tx_load;
    set_vec[ST_TX_DONE] = tx_end && !hold_full;
    set_vec[ST_RX_DONE] = rx_complete;
  end

  // master receive clock runs whenever reception is on
  assign rx_clock_pin_out = sclk || !rx_ctrl.rx_enable;
  assign rx_clock_pin_oe_n = !(rx_master && rx_ctrl.rx_enable);

  // request pulses toward the interrupt controller
  always_ff @(posedge clk) begin
    if (!resetn) begin
      rx_done_irq <= 1'b0;
      tx_empty_irq <= 1'b0;
      tx_done_irq <= 1'b0;
    end else begin
      rx_done_irq <= rx_complete && rx_ctrl.rx_done_irq_enable;
      tx_empty_irq <= set_vec[ST_TX_EMPTY] && tx_ctrl.tx_empty_irq_enable;
      tx_done_irq <= set_vec[ST_TX_DONE] && tx_ctrl.tx_done_irq_enable;
    end
  end

  // ==========================================================
  // assertions
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  sequence s_buf_write_idle;
    wr_buf && tx_state == TX_IDLE && !hold_full;
  endsequence
  sequence s_loaded;
    tx_state == TX_WAIT && status[ST_TX_EMPTY];
  endsequence

  a_rx_ctrl_reset: assert property (!$past(resetn) |-> rx_ctrl == RX_CTRL_RESET)
    else $error("receive control not zero after reset");
  a_status_high_zero: assert property (rd_stb && addr == ADDR_STATUS
    |=> rdata[7:6] == 2'b00)
    else $error("status high bits not zero");
  a_tx_fixed_one: assert property (rd_stb && addr == ADDR_TX_CTRL
    |=> rdata[TX_FIXED_BIT])
    else $error("transmit control bit 2 not one");
  a_status_sticky: assert property (status[ST_RX_DONE] && !wr_st
    |=> status[ST_RX_DONE])
    else $error("status bit cleared by hardware");
  a_overrun_set: assert property (rx_complete && rx_unread |=> status[ST_OVERRUN])
    else $error("overrun not flagged");
  a_seven_bit_top: assert property (rx_complete && rx_ctrl.rx_length_select
    |=> rx_buf[7])
    else $error("seven-bit buffer top bit not one");
  a_tx_load_time: assert property (s_buf_write_idle |=> ##1 s_loaded)
    else $error("transmit shifter not loaded one clock after write");
  // a fresh enable may leave idle one cycle later, so only the next cycle is pinned
  a_rx_disabled: assert property (!rx_ctrl.rx_enable
    |=> rx_state == RX_IDLE && !rx_complete)
    else $error("receiver active while disabled");
  a_errors_frozen: assert property (!rx_complete && !wr_st
    |=> status[2:0] == $past(status[2:0]))
    else $error("error bits changed outside completion");

endmodule : dmsp_serial_port

// [dmsp_peer.sv]
// Purpose: remote serial peer for the dual mode serial port
// Assumes: asynchronous frames only, bit period given in clk cycles
// Notes: idle line is high, like a pulled-up receive data pin
module dmsp_peer #(
  parameter int BIT = 32
) (
  input wire logic clk,
  input wire logic line_in,
  output logic line_out
);
  // ==========================================================
  // line idles high between frames
  initial begin
    line_out = 1'b1;
  end

  // ==========================================================
  // one frame out: start, data lsb first, optional parity, one stop
  task automatic send(input logic [7:0] d, input int n, input logic pe,
                      input logic pb, input logic sb);
    int i;
    line_out <= 1'b0;
    repeat (BIT) @(posedge clk);
    for (i = 0; i < n; i++) begin
      line_out <= d[i];
      repeat (BIT) @(posedge clk);
    end
    if (pe) begin
      line_out <= pb;
      repeat (BIT) @(posedge clk);
    end
    line_out <= sb; // a low stop is how a framing fault is made
    repeat (BIT) @(posedge clk);
    line_out <= 1'b1;
    repeat (2 * BIT) @(posedge clk);
  endtask : send

  // ==========================================================
  // one frame in, sampled at bit centres; bounded wait for the start
  task automatic recv(output logic [7:0] d, output logic ok);
    int i;
    d = 8'h00;
    for (i = 0; i < 4000 && line_in !== 1'b0; i++) @(posedge clk);
    repeat (BIT / 2) @(posedge clk);
    ok = (line_in === 1'b0);
    for (i = 0; i < 8; i++) begin
      repeat (BIT) @(posedge clk);
      d[i] = line_in;
    end
    repeat (BIT) @(posedge clk);
    ok = ok && (line_in === 1'b1);
  endtask : recv
endmodule : dmsp_peer

// [tb_top.sv]
// Purpose: register and frame level tests of the serial port
// Assumes: reload FE gives a 2-clock baud tick, so a 32-clock bit
// Notes: the peer drives the receive line and checks the transmit line
module tb_top
  import dmsp_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int BIT = 32;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic [2:0] addr = 3'h0;
  logic [7:0] wdata = 8'h00;
  logic wr_stb = 1'b0;
  logic rd_stb = 1'b0;
  logic [7:0] rdata;
  logic rxd;
  logic txd;
  logic rx_irq;
  logic te_irq;
  logic td_irq;
  logic xclk = 1'b0;
  logic rxc_out;
  logic rxc_oe_n;
  logic txc_out;
  logic txc_oe_n;
  int n_te = 0;
  int n_td = 0;
  int n_mismatch = 0;
  int n_compared = 0;
  int n_irq = 0;
  logic [7:0] v;
  logic ok;

  // ==========================================================
  // clock, design and peer
  always #4 clk = ~clk;

  dmsp_serial_port dut (
    .clk(clk), .resetn(resetn), .addr(addr), .wdata(wdata), .wr_stb(wr_stb),
    .rd_stb(rd_stb), .rdata(rdata), .rx_data_pin(rxd), .tx_data_pin(txd),
    .rx_clock_pin_in(xclk), .rx_clock_pin_out(rxc_out), .rx_clock_pin_oe_n(rxc_oe_n),
    .tx_clock_pin_in(xclk), .tx_clock_pin_out(txc_out), .tx_clock_pin_oe_n(txc_oe_n),
    .rx_done_irq(rx_irq), .tx_empty_irq(te_irq), .tx_done_irq(td_irq)
  );

  dmsp_peer #(.BIT(BIT)) peer (.clk(clk), .line_in(txd), .line_out(rxd));

  // request pulses counted, since each stands a single cycle
  always @(posedge clk) begin
    if (rx_irq === 1'b1) n_irq++;
    if (te_irq === 1'b1) n_te++;
    if (td_irq === 1'b1) n_td++;
  end

  // external baud clock, rising every 2 clocks like the timer at reload FE
  always @(posedge clk) begin
    xclk <= ~xclk;
  end

  // ==========================================================
  // bus and compare tasks
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    addr <= a;
    wdata <= d;
    wr_stb <= 1'b1;
    @(posedge clk);
    wr_stb <= 1'b0;
    // one edge passes so a following call never re-raises the strobe in this step
    @(posedge clk);
  endtask : wr

  // read data is taken at the edge that closes the answer cycle
  task automatic rd(input logic [2:0] a, output logic [7:0] d);
    addr <= a;
    rd_stb <= 1'b1;
    @(posedge clk);
    rd_stb <= 1'b0;
    @(posedge clk);
    d = rdata;
  endtask : rd

  task automatic chk(input string nm, input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  task automatic rchk(input string nm, input logic [2:0] a, input logic [7:0] e);
    logic [7:0] r;
    rd(a, r);
    chk(nm, r, e);
  endtask : rchk

  // enable is dropped before any other receive setting moves
  task automatic set_rx(input logic [7:0] c);
    wr(ADDR_RX_CTRL, 8'h00);
    wr(ADDR_RX_CTRL, c);
    wr(ADDR_STATUS, 8'h00);
  endtask : set_rx

  task automatic test_done;
    if (n_mismatch == 0 && n_compared > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : test_done

  // ==========================================================
  // watchdog, well beyond the ten frames of the run
  initial begin
    repeat (60000) @(posedge clk);
    n_mismatch++;
    test_done;
  end

  // ==========================================================
  // main sequence
  initial begin
    repeat (2) @(posedge clk);
    resetn <= 1'b1;
    rchk("rx_ctrl", ADDR_RX_CTRL, 8'h00);
    rchk("status", ADDR_STATUS, 8'h00);
    rchk("tx_ctrl", ADDR_TX_CTRL, 8'h04);
    chk("clk_pins", {4'h0, txc_out, rxc_out, rxc_oe_n, txc_oe_n}, 8'h0F);
    rchk("unmapped", 3'h5, 8'h00);
    wr(ADDR_RX_CTRL, 8'h5A);
    rchk("rx_ctrl", ADDR_RX_CTRL, 8'h5A);
    wr(ADDR_STATUS, 8'hFF);
    rchk("status", ADDR_STATUS, 8'h3F);
    wr(ADDR_TX_CTRL, 8'hC8);
    rchk("tx_ctrl", ADDR_TX_CTRL, 8'hCC);
    wr(ADDR_RELOAD, 8'hFE);
    set_rx(8'h00);
    rchk("status", ADDR_STATUS, 8'h00);
    // transmit one byte and catch it on the far side
    wr(ADDR_BUFFER, 8'hA5);
    peer.recv(v, ok);
    chk("tx_byte", v, 8'hA5);
    chk("tx_frame", {7'h00, ok}, 8'h01);
    repeat (BIT) @(posedge clk);
    rchk("status", ADDR_STATUS, 8'h18);
    chk("tx_irqs", {n_te[3:0], n_td[3:0]}, 8'h11);
    // reception off: nothing may be taken in
    wr(ADDR_STATUS, 8'h00);
    peer.send(8'h11, 8, 1'b0, 1'b0, 1'b1);
    rchk("status", ADDR_STATUS, 8'h00);
    // plain reception with the request enabled
    set_rx(8'hC0);
    peer.send(8'h3C, 8, 1'b0, 1'b0, 1'b1);
    rchk("status", ADDR_STATUS, 8'h20);
    chk("irq_count", n_irq[7:0], 8'h01);
    rchk("rx_byte", ADDR_BUFFER, 8'h3C);
    rchk("status", ADDR_STATUS, 8'h20);
    // two frames with no read between them
    set_rx(8'h80);
    peer.send(8'h5A, 8, 1'b0, 1'b0, 1'b1);
    peer.send(8'h66, 8, 1'b0, 1'b0, 1'b1);
    rchk("status", ADDR_STATUS, 8'h22);
    rchk("rx_byte", ADDR_BUFFER, 8'h66);
    chk("irq_count", n_irq[7:0], 8'h01);
    // even parity: wrong bit, then right bit
    set_rx(8'h90);
    peer.send(8'h0F, 8, 1'b1, 1'b1, 1'b1);
    rchk("status", ADDR_STATUS, 8'h24);
    rchk("rx_byte", ADDR_BUFFER, 8'h0F);
    wr(ADDR_STATUS, 8'h00);
    peer.send(8'h0F, 8, 1'b1, 1'b0, 1'b1);
    rchk("status", ADDR_STATUS, 8'h20);
    rd(ADDR_BUFFER, v);
    // stop bit low
    set_rx(8'h80);
    peer.send(8'h33, 8, 1'b0, 1'b0, 1'b0);
    rchk("status", ADDR_STATUS, 8'h21);
    rd(ADDR_BUFFER, v);
    // seven-bit characters
    set_rx(8'h82);
    peer.send(8'h55, 7, 1'b0, 1'b0, 1'b1);
    rchk("rx_byte", ADDR_BUFFER, 8'hD5);
    // baud taken from the receive clock pin instead of the timer
    set_rx(8'h84);
    peer.send(8'h4B, 8, 1'b0, 1'b0, 1'b1);
    rchk("rx_byte", ADDR_BUFFER, 8'h4B);
    test_done;
  end
endmodule : tb_top
